// ---- rtl/ntw_pkg.sv ----
// Constants, field layouts and shared helpers for the bridge address window setup block.
// How it works
// - Every configuration write latches requester function, device and bus numbers, read-only.
// - Setup bit 0 picks memory (0) or I/O (1) space for the window.
// - Window 0 type 0x0 is 32-bit, 0x2 is 64-bit; reported in the window.
// - Selecting I/O space forces the setup type field to zero.
// - Window 1 only accepts type 0x0; it never decodes 64-bit alone.
// - Setup bit 3 sets the prefetchable indication the window reports.
// - Size field gives aperture of two to the size bytes; zero decodes every base bit, as size four does.
// - Base field bit zero stands for transaction address bit four.
// - Base bits at or above size are writable; those below read zero.
// - Nonzero size below four makes the whole base field read-only zero.
// - In I/O or 32-bit mode, size above 32 leaves upper bits unused.
// - Setup bit 31 enables the window; disabled windows read as zero.
// - Setup and translation fields survive link (hot) resets; only the power-on reset clears them.
// - Window 0 translation bits 31:4 translate; paired, window 1 supplies upper word.
// - Memory 64-bit window 0 absorbs window 1; window 1 setup reads zero.
// - While paired, all 32 bits of window 1 translation are read-write.
// - Window 1 alone translates with its own translation bits 31:4.
// - Translation replaces address bits 31 down to size with translated bits.
package ntw_pkg;

  // ==========================================================================
  // Register numbers (configuration dword index)
  localparam logic [9:0] NTW_REG_BAR0 = 10'h004;
  localparam logic [9:0] NTW_REG_BAR1 = 10'h005;
  localparam logic [9:0] NTW_REG_WRITER_ID = 10'h07A;
  localparam logic [9:0] NTW_REG_W0_CFG = 10'h07C;
  localparam logic [9:0] NTW_REG_W0_XLAT = 10'h080;
  localparam logic [9:0] NTW_REG_W1_CFG = 10'h084;
  localparam logic [9:0] NTW_REG_W1_XLAT = 10'h088;

  // ==========================================================================
  // Setup register fields
  localparam int NTW_SPACE_BIT = 0;
  localparam int NTW_TYPE_LSB = 1;
  localparam int NTW_READAHEAD_PERMITTED_SELECT_BIT = 3;
  localparam int NTW_SIZE_LSB = 4;
  localparam int NTW_EN_BIT = 31;
  localparam int NTW_BASE_LSB = 4;
  localparam int NTW_ADDR_HALF = 32;
  localparam logic [1:0] NTW_TYPE_32 = 2'h0;
  localparam logic [1:0] NTW_TYPE_64 = 2'h2;
  localparam logic [5:0] NTW_SIZE_FULL = 6'h00;
  localparam logic [5:0] NTW_SIZE_MIN = 6'h04;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] NTW_RST_WORD = 32'h0000_0000;
  localparam logic [63:0] NTW_RST_BASE = 64'h0000_0000_0000_0000;
  localparam logic [15:0] NTW_RST_ID = 16'h0000;

  // Returns the writable bits of a window base address for a size and width.
  function automatic logic [63:0] ntw_base_mask(input logic [5:0] size, input logic wide);
    logic [63:0] m;
    m = '0;
    for (int i = NTW_BASE_LSB; i < 64; i++) begin
      m[i] = ((size == NTW_SIZE_FULL) || ({1'b0, size} <= 7'(i))) && (wide || (i < NTW_ADDR_HALF));
    end
    if ((size != NTW_SIZE_FULL) && (size < NTW_SIZE_MIN)) begin
      m = '0;
    end
    return m;
  endfunction : ntw_base_mask

  // Merges write data into a word under byte enables.
  function automatic logic [31:0] ntw_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : ntw_merge

endpackage : ntw_pkg

// ---- rtl/ntw_id_capture.sv ----
// Holder of the requester ID of the most recent configuration write.
`timescale 1ns/1ps
module ntw_id_capture
  import ntw_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic link_reset,
  input wire logic cfg_write,
  input wire logic [15:0] requester_id,
  output logic [15:0] id_q
);

  logic [15:0] id_d;

  // ==========================================================================
  // Capture
  always_comb begin
    id_d = id_q;
    // A write in the same cycle as a link reset is kept, so no writer is lost.
    if (cfg_write) begin
      id_d = requester_id;
    end else if (link_reset) begin
      id_d = NTW_RST_ID;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      id_q <= NTW_RST_ID;
    end else begin
      id_q <= id_d;
    end
  end

endmodule : ntw_id_capture

// ---- rtl/ntw_window.sv ----
// Hit test and address translation for one address window.
`timescale 1ns/1ps
module ntw_window
  import ntw_pkg::*;
(
  input wire logic enable,
  input wire logic space_io,
  input wire logic wide,
  input wire logic [5:0] size,
  input wire logic [63:0] base,
  input wire logic [31:0] xlat_lo,
  input wire logic [31:0] xlat_hi,
  input wire logic [63:0] req_addr,
  input wire logic req_is_io,
  output logic hit,
  output logic [63:0] xlat_addr
);

  logic [63:0] mask;
  logic [63:0] repl;

  // ==========================================================================
  // Decode and translation
  always_comb begin
    mask = ntw_base_mask(size, wide);
    hit = enable && (mask != '0) && (space_io == req_is_io)
          && ((req_addr & mask) == (base & mask))
          && (wide || (req_addr[63:32] == 32'h0000_0000));
    repl = ntw_base_mask(size, 1'b1);
    xlat_addr = req_addr;
    for (int i = NTW_BASE_LSB; i < NTW_ADDR_HALF; i++) begin
      if (repl[i]) begin
        xlat_addr[i] = xlat_lo[i];
      end
    end
    for (int i = NTW_ADDR_HALF; i < 64; i++) begin
      if (wide && repl[i]) begin
        xlat_addr[i] = xlat_hi[i - NTW_ADDR_HALF];
      end
    end
  end

endmodule : ntw_window

// ---- rtl/ntw_bar_window_setup.sv ----
// Configuration registers, hit test and translation for the first two bridge windows.
`timescale 1ns/1ps
module ntw_bar_window_setup
  import ntw_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic link_reset,
  input wire logic cfg_req_valid,
  input wire logic cfg_req_write,
  input wire logic [9:0] cfg_req_reg,
  input wire logic [3:0] cfg_req_be,
  input wire logic [31:0] cfg_req_wdata,
  input wire logic [15:0] cfg_req_id,
  output logic cfg_ack_q,
  output logic [31:0] cfg_rdata_q,
  input wire logic req_valid,
  input wire logic req_is_io,
  input wire logic [63:0] req_addr,
  output logic xlat_valid_q,
  output logic hit0_q,
  output logic hit1_q,
  output logic [63:0] xlat_addr_q,
  output logic [15:0] last_config_writer_id
);

  // ==========================================================================
  // Window configuration state
  logic space0_q;
  logic space0_d;
  logic pref0_q;
  logic pref0_d;
  logic en0_q;
  logic en0_d;
  logic [1:0] type0_q;
  logic [1:0] type0_d;
  logic [5:0] size0_q;
  logic [5:0] size0_d;
  logic space1_q;
  logic space1_d;
  logic pref1_q;
  logic pref1_d;
  logic en1_q;
  logic en1_d;
  logic [5:0] size1_q;
  logic [5:0] size1_d;
  logic [31:0] xlat0_q;
  logic [31:0] xlat0_d;
  logic [31:0] xlat1_q;
  logic [31:0] xlat1_d;
  logic [63:0] base0_q;
  logic [63:0] base0_d;
  logic [31:0] base1_q;
  logic [31:0] base1_d;

  // Window 0 in memory space with 64-bit decoding takes window 1 over as its upper half.
  logic paired;
  logic [63:0] mask0;
  logic [63:0] mask1;
  logic [63:0] base0_v;
  logic [63:0] base1_v;
  logic wr;

  // Current register contents merged with the write data under the byte enables.
  logic [31:0] m_cfg0;
  logic [31:0] m_cfg1;
  logic [31:0] m_x0;
  logic [31:0] m_x1;
  logic [31:0] m_b0;
  logic [31:0] m_b1;
  logic [1:0] new_type0;

  assign paired = (space0_q == 1'b0) && (type0_q == NTW_TYPE_64);
  assign mask0 = ntw_base_mask(size0_q, paired);
  assign mask1 = ntw_base_mask(size1_q, 1'b0);
  assign base0_v = base0_q & mask0;
  assign base1_v = {32'h0000_0000, base1_q} & mask1;
  assign wr = cfg_req_valid && cfg_req_write;

  always_comb begin
    m_cfg0 = ntw_merge({en0_q, 21'h00_0000, size0_q, pref0_q, type0_q, space0_q}, cfg_req_wdata, cfg_req_be);
    m_cfg1 = ntw_merge({en1_q, 21'h00_0000, size1_q, pref1_q, 2'b00, space1_q}, cfg_req_wdata, cfg_req_be);
    m_x0 = ntw_merge(xlat0_q, cfg_req_wdata, cfg_req_be);
    m_x1 = ntw_merge(xlat1_q, cfg_req_wdata, cfg_req_be);
    m_b0 = ntw_merge(base0_v[31:0], cfg_req_wdata, cfg_req_be);
    m_b1 = ntw_merge(paired ? base0_v[63:32] : base1_v[31:0], cfg_req_wdata, cfg_req_be);
    // Reserved encodings and any type chosen together with I/O space fall back to 32-bit decoding.
    new_type0 = m_cfg0[NTW_TYPE_LSB +: 2];
    if (m_cfg0[NTW_SPACE_BIT] || (new_type0 != NTW_TYPE_64)) begin
      new_type0 = NTW_TYPE_32;
    end
  end

  // ==========================================================================
  // Register writes; only the power-on reset clears these, not link resets
  always_comb begin
    space0_d = space0_q;
    type0_d = type0_q;
    pref0_d = pref0_q;
    size0_d = size0_q;
    en0_d = en0_q;
    space1_d = space1_q;
    pref1_d = pref1_q;
    size1_d = size1_q;
    en1_d = en1_q;
    xlat0_d = xlat0_q;
    xlat1_d = xlat1_q;
    base0_d = base0_q;
    base1_d = base1_q;
    // Writes to refused registers or read-only bits are dropped but still answered.
    if (wr) begin
      unique case (cfg_req_reg)
        NTW_REG_W0_CFG: begin
          space0_d = m_cfg0[NTW_SPACE_BIT];
          type0_d = new_type0;
          pref0_d = m_cfg0[NTW_READAHEAD_PERMITTED_SELECT_BIT];
          size0_d = m_cfg0[NTW_SIZE_LSB +: 6];
          en0_d = m_cfg0[NTW_EN_BIT];
        end
        NTW_REG_W1_CFG: begin
          if (!paired) begin
            space1_d = m_cfg1[NTW_SPACE_BIT];
            pref1_d = m_cfg1[NTW_READAHEAD_PERMITTED_SELECT_BIT];
            size1_d = m_cfg1[NTW_SIZE_LSB +: 6];
            en1_d = m_cfg1[NTW_EN_BIT];
          end
        end
        NTW_REG_W0_XLAT: begin
          xlat0_d = {m_x0[31:4], 4'h0};
        end
        NTW_REG_W1_XLAT: begin
          xlat1_d = paired ? m_x1 : {m_x1[31:4], 4'h0};
        end
        NTW_REG_BAR0: begin
          if (en0_q) begin
            base0_d[31:0] = m_b0 & mask0[31:0];
          end
        end
        NTW_REG_BAR1: begin
          if (paired) begin
            if (en0_q) begin
              base0_d[63:32] = m_b1 & mask0[63:32];
            end
          end else if (en1_q) begin
            base1_d = m_b1 & mask1[31:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      space0_q <= 1'b0;
      type0_q <= NTW_TYPE_32;
      pref0_q <= 1'b0;
      size0_q <= NTW_SIZE_FULL;
      en0_q <= 1'b0;
      space1_q <= 1'b0;
      pref1_q <= 1'b0;
      size1_q <= NTW_SIZE_FULL;
      en1_q <= 1'b0;
      xlat0_q <= NTW_RST_WORD;
      xlat1_q <= NTW_RST_WORD;
      base0_q <= NTW_RST_BASE;
      base1_q <= NTW_RST_WORD;
    end else begin
      space0_q <= space0_d;
      type0_q <= type0_d;
      pref0_q <= pref0_d;
      size0_q <= size0_d;
      en0_q <= en0_d;
      space1_q <= space1_d;
      pref1_q <= pref1_d;
      size1_q <= size1_d;
      en1_q <= en1_d;
      xlat0_q <= xlat0_d;
      xlat1_q <= xlat1_d;
      base0_q <= base0_d;
      base1_q <= base1_d;
    end
  end

  // ==========================================================================
  // Read path
  // Every request is answered one cycle later, whether it reached a register or not.
  logic cfg_ack_d;
  logic [31:0] cfg_rdata_d;

  always_comb begin
    cfg_ack_d = cfg_req_valid;
    cfg_rdata_d = 32'h0000_0000;
    if (cfg_req_valid && !cfg_req_write) begin
      unique case (cfg_req_reg)
        NTW_REG_W0_CFG: cfg_rdata_d = {en0_q, 21'h00_0000, size0_q, pref0_q, type0_q, space0_q};
        NTW_REG_W1_CFG: cfg_rdata_d = paired ? 32'h0000_0000
                                             : {en1_q, 21'h00_0000, size1_q, pref1_q, 2'b00, space1_q};
        NTW_REG_W0_XLAT: cfg_rdata_d = xlat0_q;
        NTW_REG_W1_XLAT: cfg_rdata_d = xlat1_q;
        NTW_REG_WRITER_ID: cfg_rdata_d = {16'h0000, last_config_writer_id};
        // Base bits are masked again on read so that a later size change hides stale bits.
        NTW_REG_BAR0: cfg_rdata_d = en0_q ? {base0_v[31:4], pref0_q, type0_q, space0_q} : 32'h0000_0000;
        NTW_REG_BAR1: begin
          if (paired) begin
            cfg_rdata_d = en0_q ? base0_v[63:32] : 32'h0000_0000;
          end else begin
            cfg_rdata_d = en1_q ? {base1_v[31:4], pref1_q, 2'b00, space1_q} : 32'h0000_0000;
          end
        end
        default: cfg_rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_ack_q <= 1'b0;
      cfg_rdata_q <= NTW_RST_WORD;
    end else begin
      cfg_ack_q <= cfg_ack_d;
      cfg_rdata_q <= cfg_rdata_d;
    end
  end

  // The writer ID is taken from every configuration write, mapped or not.
  ntw_id_capture u_id (
    .clock(clock),
    .rst(rst),
    .link_reset(link_reset),
    .cfg_write(wr),
    .requester_id(cfg_req_id),
    .id_q(last_config_writer_id)
  );

  // ==========================================================================
  // Hit test and translation
  logic hit0;
  logic hit1;
  logic [63:0] xa0;
  logic [63:0] xa1;

  // Window 0 decodes the upper address word only while paired.
  ntw_window u_w0 (
    .enable(en0_q),
    .space_io(space0_q),
    .wide(paired),
    .size(size0_q),
    .base(base0_v),
    .xlat_lo(xlat0_q),
    .xlat_hi(xlat1_q),
    .req_addr(req_addr),
    .req_is_io(req_is_io),
    .hit(hit0),
    .xlat_addr(xa0)
  );

  // Window 1 stands aside while it serves as the upper half of window 0.
  ntw_window u_w1 (
    .enable(en1_q && !paired),
    .space_io(space1_q),
    .wide(1'b0),
    .size(size1_q),
    .base(base1_v),
    .xlat_lo(xlat1_q),
    .xlat_hi(32'h0000_0000),
    .req_addr(req_addr),
    .req_is_io(req_is_io),
    .hit(hit1),
    .xlat_addr(xa1)
  );

  // Window 0 wins when both windows claim the same address.
  logic xlat_valid_d;
  logic hit0_d;
  logic hit1_d;
  logic [63:0] xlat_addr_d;

  always_comb begin
    xlat_valid_d = req_valid;
    hit0_d = req_valid && hit0;
    hit1_d = req_valid && hit1 && !hit0;
    xlat_addr_d = hit0 ? xa0 : (hit1 ? xa1 : req_addr);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      xlat_valid_q <= 1'b0;
      hit0_q <= 1'b0;
      hit1_q <= 1'b0;
      xlat_addr_q <= NTW_RST_BASE;
    end else begin
      xlat_valid_q <= xlat_valid_d;
      hit0_q <= hit0_d;
      hit1_q <= hit1_d;
      xlat_addr_q <= xlat_addr_d;
    end
  end

endmodule : ntw_bar_window_setup

// ---- sim/ntw_bar_window_setup_checker.sv ----
// Port-level assertions for the bridge window setup block.
`timescale 1ns/1ps
module ntw_bar_window_setup_checker
  import ntw_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic link_reset,
  input wire logic cfg_req_valid,
  input wire logic cfg_req_write,
  input wire logic [9:0] cfg_req_reg,
  input wire logic [3:0] cfg_req_be,
  input wire logic [31:0] cfg_req_wdata,
  input wire logic [15:0] cfg_req_id,
  input wire logic cfg_ack_q,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic req_valid,
  input wire logic req_is_io,
  input wire logic [63:0] req_addr,
  input wire logic xlat_valid_q,
  input wire logic hit0_q,
  input wire logic hit1_q,
  input wire logic [63:0] xlat_addr_q,
  input wire logic [15:0] last_config_writer_id
);
  // ==========================================================================
  // Request decodes and the address taken at the previous edge.
  logic [63:0] addr_q;
  wire logic rd = cfg_req_valid && !cfg_req_write;
  wire logic wr = cfg_req_valid && cfg_req_write;
  always_ff @(posedge clock) begin
    addr_q <= req_addr;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_id_take;
    wr |=> last_config_writer_id == $past(cfg_req_id);
  endproperty
  a_id_take: assert property (p_id_take) else $error("writer id not captured");
  property p_id_keep;
    !wr && !link_reset |=> $stable(last_config_writer_id);
  endproperty
  a_id_keep: assert property (p_id_keep) else $error("writer id changed");
  property p_io_type;
    rd && (cfg_req_reg == NTW_REG_W0_CFG || cfg_req_reg == NTW_REG_W1_CFG) |=> !cfg_rdata_q[0] || !(|cfg_rdata_q[2:1]);
  endproperty
  a_io_type: assert property (p_io_type) else $error("io window kept a type");
  property p_w0_type;
    rd && cfg_req_reg == NTW_REG_W0_CFG |=> cfg_ack_q && !cfg_rdata_q[1];
  endproperty
  a_w0_type: assert property (p_w0_type) else $error("window 0 reserved type");
  property p_w1_type;
    rd && cfg_req_reg == NTW_REG_W1_CFG |=> cfg_rdata_q[2:1] == 2'h0;
  endproperty
  a_w1_type: assert property (p_w1_type) else $error("window 1 type not zero");
  property p_xlat_low;
    rd && cfg_req_reg == NTW_REG_W0_XLAT |=> cfg_ack_q && cfg_rdata_q[3:0] == 4'h0;
  endproperty
  a_xlat_low: assert property (p_xlat_low) else $error("translation low nibble set");
  property p_answer;
    req_valid |=> xlat_valid_q;
  endproperty
  a_answer: assert property (p_answer) else $error("no translation answer");
  property p_pass;
    xlat_valid_q && !hit0_q && !hit1_q |-> xlat_addr_q == addr_q;
  endproperty
  a_pass: assert property (p_pass) else $error("missed address altered");
  property p_low;
    xlat_valid_q && (hit0_q || hit1_q) |-> xlat_addr_q[3:0] == addr_q[3:0];
  endproperty
  a_low: assert property (p_low) else $error("low address bits altered");
endmodule : ntw_bar_window_setup_checker

// ---- sim/ntw_cfg_host.sv ----
// Host model issuing configuration requests to the window setup block.
`timescale 1ns/1ps
module ntw_cfg_host (
  input wire logic clock,
  input wire logic cfg_ack_q,
  input wire logic [31:0] cfg_rdata_q,
  output logic cfg_req_valid,
  output logic cfg_req_write,
  output logic [9:0] cfg_req_reg,
  output logic [3:0] cfg_req_be,
  output logic [31:0] cfg_req_wdata,
  output logic [15:0] cfg_req_id
);
  initial begin
    cfg_req_valid = 1'b0;
    cfg_req_write = 1'b0;
    cfg_req_reg = 10'h000;
    cfg_req_be = 4'h0;
    cfg_req_wdata = 32'h0000_0000;
    cfg_req_id = 16'h0000;
  end
  // One request, held for its taking edge; idle data lines are inverted so stale values never look valid.
  task automatic xfer(input logic w, input logic [9:0] r, input logic [31:0] d, input logic [3:0] be,
                      input logic [15:0] id, output logic ack, output logic [31:0] q);
    @(posedge clock);
    cfg_req_valid <= 1'b1;
    cfg_req_write <= w;
    cfg_req_reg <= r;
    cfg_req_be <= be;
    cfg_req_wdata <= d;
    cfg_req_id <= id;
    @(posedge clock);
    cfg_req_valid <= 1'b0;
    cfg_req_wdata <= ~d;
    cfg_req_id <= ~id;
    #1;
    ack = cfg_ack_q;
    q = cfg_rdata_q;
  endtask : xfer
endmodule : ntw_cfg_host

// ---- sim/tb_ntw_bar_window_setup.sv ----
// Self-checking bench for the bridge window setup block.
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp=%h got=%h", n, e, g); end end
module tb_ntw_bar_window_setup
  import ntw_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic link_reset = 1'b0;
  logic req_valid = 1'b0;
  logic req_is_io = 1'b0;
  logic [63:0] req_addr = 64'h0;
  wire logic cfg_req_valid, cfg_req_write, cfg_ack_q, xlat_valid_q, hit0_q, hit1_q;
  wire logic [9:0] cfg_req_reg;
  wire logic [3:0] cfg_req_be;
  wire logic [31:0] cfg_req_wdata, cfg_rdata_q;
  wire logic [15:0] cfg_req_id, last_config_writer_id;
  wire logic [63:0] xlat_addr_q;
  integer err_count = 0;
  integer compares = 0;
  integer seed = 14414;
  logic ak;
  logic [31:0] q, b, t;
  logic [15:0] id;
  logic [9:0] rl[6] = '{NTW_REG_W0_CFG, NTW_REG_W0_XLAT, NTW_REG_W1_CFG, NTW_REG_W1_XLAT, NTW_REG_BAR0, NTW_REG_WRITER_ID};
  logic [31:0] cw[3] = '{32'h8000_0078, 32'h8000_0077, 32'h8000_0072};
  logic [31:0] ce[3] = '{32'h8000_0078, 32'h8000_0071, 32'h8000_0070};
  always #5 clock = ~clock;
  ntw_cfg_host u_host (.clock(clock), .cfg_ack_q(cfg_ack_q), .cfg_rdata_q(cfg_rdata_q),
    .cfg_req_valid(cfg_req_valid), .cfg_req_write(cfg_req_write), .cfg_req_reg(cfg_req_reg),
    .cfg_req_be(cfg_req_be), .cfg_req_wdata(cfg_req_wdata), .cfg_req_id(cfg_req_id));
  ntw_bar_window_setup u_dut (.clock(clock), .rst(rst), .link_reset(link_reset), .cfg_req_valid(cfg_req_valid),
    .cfg_req_write(cfg_req_write), .cfg_req_reg(cfg_req_reg), .cfg_req_be(cfg_req_be),
    .cfg_req_wdata(cfg_req_wdata), .cfg_req_id(cfg_req_id), .cfg_ack_q(cfg_ack_q), .cfg_rdata_q(cfg_rdata_q),
    .req_valid(req_valid), .req_is_io(req_is_io), .req_addr(req_addr), .xlat_valid_q(xlat_valid_q),
    .hit0_q(hit0_q), .hit1_q(hit1_q), .xlat_addr_q(xlat_addr_q), .last_config_writer_id(last_config_writer_id));
  // ==========================================================================
  // Bus tasks and expectation helpers.
  function automatic logic [31:0] bm(input logic [5:0] s);
    if (s == 6'h00) begin
      return 32'hFFFF_FFF0;
    end
    if (s < 6'h04) begin
      return 32'h0000_0000;
    end
    return 32'(~((64'h1 << s) - 64'h1)) & 32'hFFFF_FFF0;
  endfunction : bm
  task automatic wr(input logic [9:0] r, input logic [31:0] d);
    u_host.xfer(1'b1, r, d, 4'hF, 16'h0000, ak, q);
  endtask : wr
  task automatic chk_rd(input string n, input logic [9:0] r, input logic [31:0] e);
    u_host.xfer(1'b0, r, 32'h0000_0000, 4'hF, 16'h0000, ak, q);
    `CHK(n, {1'b1, e}, {ak, q})
  endtask : chk_rd
  task automatic xl(input logic io, input logic [63:0] a, input logic h0, input logic h1, input logic [63:0] e);
    @(posedge clock);
    req_valid <= 1'b1;
    req_is_io <= io;
    req_addr <= a;
    @(posedge clock);
    req_valid <= 1'b0;
    req_addr <= ~a;
    #1;
    `CHK("hit", {1'b1, h0, h1}, {xlat_valid_q, hit0_q, hit1_q})
    `CHK("xaddr", e, xlat_addr_q)
  endtask : xl
  task automatic win0(input logic [5:0] s);
    logic [31:0] a;
    wr(NTW_REG_W0_CFG, {1'b1, 21'h0, s, 4'h0});
    b = $random(seed);
    t = $random(seed);
    wr(NTW_REG_BAR0, b);
    chk_rd("bar0", NTW_REG_BAR0, b & bm(s));
    wr(NTW_REG_W0_XLAT, t);
    chk_rd("xlat0", NTW_REG_W0_XLAT, t & 32'hFFFF_FFF0);
    a = (b & bm(s)) | ($random(seed) & ~bm(s));
    xl(1'b0, {32'h0, a}, bm(s) != 0, 1'b0, {32'h0, a ^ ((a ^ t) & bm(s))});
    xl(1'b0, {32'h0, a ^ 32'h8000_0000}, 1'b0, 1'b0, {32'h0, a ^ 32'h8000_0000});
  endtask : win0
  task automatic conclude();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    foreach (rl[i]) chk_rd("reset", rl[i], 32'h0);
    for (int i = 0; i < 3; i++) begin
      id = 16'($random(seed));
      u_host.xfer(1'b1, NTW_REG_W0_CFG, cw[i], 4'hF, id, ak, q);
      `CHK("id", id, last_config_writer_id)
      chk_rd("w0cfg", NTW_REG_W0_CFG, ce[i]);
      chk_rd("bar0lo", NTW_REG_BAR0, {28'h0, ce[i][3:0]});
    end
    wr(NTW_REG_W1_CFG, 32'h8000_0074);
    chk_rd("w1cfg", NTW_REG_W1_CFG, 32'h8000_0070);
    wr(NTW_REG_W0_CFG, 32'h0000_0070);
    wr(NTW_REG_BAR0, 32'hFFFF_FFFF);
    chk_rd("bar0off", NTW_REG_BAR0, 32'h0);
    wr(NTW_REG_W1_CFG, 32'h0000_0000);
    win0(6'd7);
    win0(6'd31);
    win0(6'd0);
    win0(6'd3);
    win0(6'd4);
    for (int i = 0; i < 20; i++) win0(6'd7 + 6'($unsigned($random(seed)) % 25));
    wr(NTW_REG_W0_CFG, 32'h0000_0000);
    wr(NTW_REG_W1_CFG, 32'h8000_004F);
    chk_rd("w1io", NTW_REG_W1_CFG, 32'h8000_0049);
    wr(NTW_REG_BAR1, 32'h0000_1238);
    chk_rd("bar1", NTW_REG_BAR1, 32'h0000_1239);
    wr(NTW_REG_W1_XLAT, 32'h5555_AAAF);
    chk_rd("xlat1lo", NTW_REG_W1_XLAT, 32'h5555_AAA0);
    xl(1'b1, 64'h0000_0000_0000_1237, 1'b0, 1'b1, 64'h0000_0000_5555_AAA7);
    xl(1'b0, 64'h0000_0000_0000_1237, 1'b0, 1'b0, 64'h0000_0000_0000_1237);
    xl(1'b1, 64'h0000_0001_0000_1237, 1'b0, 1'b0, 64'h0000_0001_0000_1237);
    wr(NTW_REG_W0_CFG, 32'h8000_0084);
    chk_rd("w1pair", NTW_REG_W1_CFG, 32'h0);
    wr(NTW_REG_W1_CFG, 32'h8000_0070);
    chk_rd("w1lock", NTW_REG_W1_CFG, 32'h0);
    wr(NTW_REG_W1_XLAT, 32'hFFFF_FFFF);
    chk_rd("xlat1", NTW_REG_W1_XLAT, 32'hFFFF_FFFF);
    wr(NTW_REG_BAR0, 32'h1234_5678);
    chk_rd("bar0p", NTW_REG_BAR0, 32'h1234_5604);
    wr(NTW_REG_BAR1, 32'h0000_0009);
    chk_rd("bar1p", NTW_REG_BAR1, 32'h0000_0009);
    wr(NTW_REG_W0_XLAT, 32'hABCD_0000);
    xl(1'b0, 64'h0000_0009_1234_56A5, 1'b1, 1'b0, 64'hFFFF_FFFF_ABCD_00A5);
    xl(1'b0, 64'h0000_0008_1234_56A5, 1'b0, 1'b0, 64'h0000_0008_1234_56A5);
    id = 16'($random(seed)) | 16'h0001;
    u_host.xfer(1'b1, NTW_REG_W1_XLAT, 32'h0000_0012, 4'h1, id, ak, q);
    `CHK("idlast", id, last_config_writer_id)
    @(posedge clock);
    link_reset <= 1'b1;
    @(posedge clock);
    link_reset <= 1'b0;
    #1;
    `CHK("idclr", 16'h0, last_config_writer_id)
    chk_rd("keep", NTW_REG_W0_CFG, 32'h8000_0084);
    chk_rd("keepx", NTW_REG_W1_XLAT, 32'hFFFF_FF12);
    conclude();
  end
endmodule : tb_ntw_bar_window_setup
bind ntw_bar_window_setup ntw_bar_window_setup_checker u_chk (.clock(clock), .rst(rst), .link_reset(link_reset),
  .cfg_req_valid(cfg_req_valid), .cfg_req_write(cfg_req_write), .cfg_req_reg(cfg_req_reg), .cfg_req_be(cfg_req_be),
  .cfg_req_wdata(cfg_req_wdata), .cfg_req_id(cfg_req_id), .cfg_ack_q(cfg_ack_q), .cfg_rdata_q(cfg_rdata_q),
  .req_valid(req_valid), .req_is_io(req_is_io), .req_addr(req_addr), .xlat_valid_q(xlat_valid_q),
  .hit0_q(hit0_q), .hit1_q(hit1_q), .xlat_addr_q(xlat_addr_q), .last_config_writer_id(last_config_writer_id));
